/* File: logic/irs_pkg.sv */
/*
  Shared constants and carrier types for the I2C register access target.
  Assumes a single 125 MHz system clock and an external register file.
*/
package irs_pkg;

  // System clock rate
  localparam int CLK_MHZ = 125;

  // Spike suppression on SCL and SDA, least time rounded up
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;

  // Fast-mode SCL limit and the shortest SCL low time it allows
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_LOW_MIN_NS = 1300;
  localparam int SCL_LOW_MIN_CYC = (SCL_LOW_MIN_NS * CLK_MHZ) / 1000;

  // Synchroniser depth in front of the filter
  localparam int SYNC_STAGES = 2;

  // Target address: bit 7 zero, bit 6 from the select pin, bits 5..1 fixed
  localparam logic ADDR_TOP = 1'b0;
  localparam logic [4:0] ADDR_FIXED = 5'h1d;
  localparam int ADDR_SEL_POS = 6;

  // Bit counts within a byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // Values after reset
  localparam logic [7:0] REG_ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic PIN_IDLE = 1'b1;

  // Protocol states
  typedef enum logic [3:0] {
    irs_idle, irs_addr, irs_addr_ack, irs_cmd, irs_cmd_ack,
    irs_data, irs_data_ack, irs_tx, irs_tx_ack, irs_ignore
  } irs_state_t;

  // Pins seen by the sampling filter
  typedef struct packed {
    logic scl;
    logic sda;
    logic adr_sel;
  } irs_pins_t;

  // Request to the register file
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } irs_req_t;

endpackage : irs_pkg

/* File: logic/irs_pin_filter.sv */
/*
  Two-flop synchroniser and spike filter, one lane per input bit.
  Assumes asynchronous pins; outputs are registered and idle high.
*/
`timescale 1ns/10ps
module irs_pin_filter #(
  parameter int W = 3,
  parameter int FILT_CYC = irs_pkg::SPIKE_CYC
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [W-1:0] din, // Raw pin levels
  output logic [W-1:0] dout // Synchronised, filtered levels
);

  // Filter counter is four bits wide
  if (W < 1 || FILT_CYC < 1 || FILT_CYC > 15) begin : g_bad_filt
    $error("irs_pin_filter: FILT_CYC out of range");
  end

  for (genvar i = 0; i < W; i++) begin : g_lane
    logic s1;
    logic s2;
    logic [3:0] cnt;

    // Two-flop synchroniser; only s2 reads s1
    always_ff @(posedge clk) begin
      if (srst) begin
        s1 <= irs_pkg::PIN_IDLE;
        s2 <= irs_pkg::PIN_IDLE;
      end else begin
        s1 <= din[i];
        s2 <= s1;
      end
    end

    // Output follows only a level that stays for FILT_CYC cycles
    always_ff @(posedge clk) begin
      if (srst) begin
        cnt <= 4'h0;
        dout[i] <= irs_pkg::PIN_IDLE;
      end else if (s2 == dout[i]) begin
        cnt <= 4'h0;
      end else if (cnt == 4'(FILT_CYC - 1)) begin
        cnt <= 4'h0;
        dout[i] <= s2;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

endmodule : irs_pin_filter

/* File: logic/irs_target.sv */
/*
  I2C target giving a host single-byte access to an external register file.
  Assumes SCL and SDA are open-drain pins resolved outside, a register file
  on the same clock that answers a read one cycle after the read pulse.
*/
// How it works
// - Address byte: bit7 zero, bit6 select pin, bits5..1 are 11101, bit0 R/W.
// - Filtered sampling keeps up with SCL up to 400 kHz fast mode.
// - Read command phase: a write carrying one byte, stored as register address.
// - Read data phase: host reads that register's byte, sent again after each host ACK, then STOP.
// - Write: address byte, register address, one data byte written to register.
// - No address auto-increment; each transaction touches one register only.
`timescale 1ns/10ps
module irs_target #(
  parameter int FILT_CYC = irs_pkg::SPIKE_CYC
) (
  input wire logic clk, // System clock, 125 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic scl_i, // SCL pin level
  input wire logic sda_i, // SDA pin level
  input wire logic adr_sel, // Address-select pin level
  output logic sda_o, // SDA output value, always low
  output logic sda_oe, // SDA pulled low while high
  output irs_pkg::irs_req_t reg_req, // Register file request
  input wire logic [7:0] reg_rdata, // Read data, cycle after reg_req.rd
  output logic busy // Transaction in progress
);

  // Edge detection plus filter delay must fit in the shortest SCL low time
  if (FILT_CYC + irs_pkg::SYNC_STAGES + 2 >= irs_pkg::SCL_LOW_MIN_CYC)
  begin : g_bad_rate
    $error("irs_target: filter too slow for fast-mode SCL");
  end

  irs_pkg::irs_pins_t raw;
  irs_pkg::irs_pins_t pin;
  irs_pkg::irs_state_t state;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_end;
  logic addr_match;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic rw;
  logic host_ack;
  logic rd_pend;
  logic [7:0] rdata_hold;

  assign raw = '{scl: scl_i, sda: sda_i, adr_sel: adr_sel};

  // Pins pass two flops and a spike filter before any logic
  irs_pin_filter #(
    .W(3),
    .FILT_CYC(FILT_CYC)
  ) u_irs_pin_filter (
    .clk(clk),
    .srst(srst),
    .din(raw),
    .dout(pin)
  );

  // Previous filtered levels for edge and bus condition detection
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q <= irs_pkg::PIN_IDLE;
      sda_q <= irs_pkg::PIN_IDLE;
    end else begin
      scl_q <= pin.scl;
      sda_q <= pin.sda;
    end
  end

  // Bus events and byte completion
  assign scl_rise = pin.scl & ~scl_q;
  assign scl_fall = ~pin.scl & scl_q;
  assign start_det = pin.scl & scl_q & sda_q & ~pin.sda;
  assign stop_det = pin.scl & scl_q & ~sda_q & pin.sda;
  assign byte_end = scl_fall & (bit_cnt == irs_pkg::BYTE_BITS);
  assign addr_match = (shreg[7:1] == {irs_pkg::ADDR_TOP, pin.adr_sel,
                                      irs_pkg::ADDR_FIXED});

  // Protocol sequencer, shift register and SDA drive
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= irs_pkg::irs_idle;
      shreg <= irs_pkg::DATA_RST;
      bit_cnt <= 4'h0;
      rw <= 1'b0;
      host_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      // Start or repeated start begins a new address byte
      state <= irs_pkg::irs_addr;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= irs_pkg::irs_idle;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        irs_pkg::irs_addr, irs_pkg::irs_cmd, irs_pkg::irs_data: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], pin.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            bit_cnt <= 4'h0;
            if (state == irs_pkg::irs_addr) begin
              if (addr_match) begin
                sda_oe <= 1'b1;
                rw <= shreg[0];
                state <= irs_pkg::irs_addr_ack;
              end else begin
                state <= irs_pkg::irs_ignore;
              end
            end else if (state == irs_pkg::irs_cmd) begin
              sda_oe <= 1'b1;
              state <= irs_pkg::irs_cmd_ack;
            end else begin
              sda_oe <= 1'b1;
              state <= irs_pkg::irs_data_ack;
            end
          end
        end
        irs_pkg::irs_addr_ack: begin
          if (scl_fall) begin
            if (rw) begin
              // Read: first data bit goes out as the ACK clock ends
              shreg <= rdata_hold;
              sda_oe <= ~rdata_hold[7];
              state <= irs_pkg::irs_tx;
            end else begin
              sda_oe <= 1'b0;
              state <= irs_pkg::irs_cmd;
            end
          end
        end
        irs_pkg::irs_cmd_ack: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= irs_pkg::irs_data;
          end
        end
        irs_pkg::irs_data_ack: begin
          if (scl_fall) begin
            // Later bytes are not acknowledged and never stored
            sda_oe <= 1'b0;
            state <= irs_pkg::irs_ignore;
          end
        end
        irs_pkg::irs_tx: begin
          if (scl_fall) begin
            if (bit_cnt == irs_pkg::LAST_TX_BIT) begin
              bit_cnt <= 4'h0;
              sda_oe <= 1'b0;
              state <= irs_pkg::irs_tx_ack;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
          end
        end
        irs_pkg::irs_tx_ack: begin
          if (scl_rise) begin
            host_ack <= ~pin.sda;
          end else if (scl_fall) begin
            if (host_ack) begin
              // More bytes wanted: the same register again, no increment
              shreg <= rdata_hold;
              sda_oe <= ~rdata_hold[7];
              state <= irs_pkg::irs_tx;
            end else begin
              state <= irs_pkg::irs_ignore;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Register file requests; the address stays until the next command
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: irs_pkg::REG_ADDR_RST,
                   wdata: irs_pkg::DATA_RST};
    end else begin
      reg_req.wr <= byte_end & ~start_det & ~stop_det
                    & (state == irs_pkg::irs_data);
      reg_req.rd <= byte_end & ~start_det & ~stop_det
                    & (state == irs_pkg::irs_addr)
                    & addr_match & shreg[0];
      if (byte_end & ~start_det & ~stop_det
          & (state == irs_pkg::irs_cmd)) begin
        reg_req.addr <= shreg;
      end
      if (byte_end & ~start_det & ~stop_det
          & (state == irs_pkg::irs_data)) begin
        reg_req.wdata <= shreg;
      end
    end
  end

  // Read data captured once, one cycle after the read pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_pend <= 1'b0;
      rdata_hold <= irs_pkg::DATA_RST;
    end else begin
      rd_pend <= reg_req.rd;
      if (rd_pend) begin
        rdata_hold <= reg_rdata;
      end
    end
  end

  // Fixed low output value and the busy flag
  always_ff @(posedge clk) begin
    if (srst) begin
      sda_o <= 1'b0;
      busy <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      busy <= (state != irs_pkg::irs_idle);
    end
  end

endmodule : irs_target

/* File: verification/irs_host.sv */
/* I2C host model driving SCL and SDA at fast-mode rate.
   Assumes SDA is resolved outside with a pull-up. */
`timescale 1ns/10ps
module irs_host (
  input wire logic clk, // System clock
  output logic scl, // SCL level
  output logic sda_h, // Host SDA, low pulls, high releases
  input wire logic sda // Resolved SDA
);
  // Quarter SCL period, 2.5 us per bit at 8 ns
  localparam int Q = 78;
  // Both lines idle released
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // Start or repeated start, SDA falls while SCL high
  task automatic start();
    sda_h = 1'b1;
    wt(Q);
    scl = 1'b1;
    wt(Q);
    sda_h = 1'b0;
    wt(Q);
    scl = 1'b0;
    wt(Q);
  endtask : start
  // Stop, SDA rises while SCL high; SCL then rests high
  task automatic stop();
    sda_h = 1'b0;
    wt(Q);
    scl = 1'b1;
    wt(Q);
    sda_h = 1'b1;
    wt(Q);
  endtask : stop
  // Nine bits MSB first, returns the wire level at each SCL high
  task automatic xb(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      sda_h = o[k];
      wt(Q);
      scl = 1'b1;
      wt(Q);
      i[k] = sda;
      wt(Q);
      scl = 1'b0;
      wt(Q);
    end
  endtask : xb
endmodule : irs_host

/* File: verification/irs_target_sva.sv */
/* Checker for the I2C register access target.
   Assumes it is bound to irs_target and sees only its ports. */
`timescale 1ns/10ps
module irs_target_sva #(
  parameter int FILT_CYC = irs_pkg::SPIKE_CYC
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic scl_i, // SCL level
  input wire logic sda_i, // SDA level
  input wire logic adr_sel, // Address select
  input wire logic sda_o, // SDA output value
  input wire logic sda_oe, // SDA pull-down enable
  input wire irs_pkg::irs_req_t reg_req, // Register request
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic busy // Transfer in progress
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // SDA only moves while SCL is low
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("SDA changed with SCL high");
  a_idle_free: assert property (!busy |-> !sda_oe)
    else $error("SDA driven while idle");
  a_drive_low: assert property (sda_oe |-> !sda_o)
    else $error("SDA driven high");
  a_ack_held: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("ACK too short");
  a_wr_once: assert property (reg_req.wr |=>
    (!reg_req.wr && $stable(reg_req.wdata)) [*8])
    else $error("write pulse repeated");
  a_rd_once: assert property (reg_req.rd |=> !reg_req.rd [*8])
    else $error("read pulse repeated");
  a_rd_addr: assert property (reg_req.rd |-> $stable(reg_req.addr))
    else $error("address moved at read");
  a_req_busy: assert property ((reg_req.wr || reg_req.rd) |-> busy)
    else $error("request outside transfer");
endmodule : irs_target_sva
bind irs_target irs_target_sva #(.FILT_CYC(FILT_CYC)) u_irs_target_sva (
  .clk(clk), .srst(srst), .scl_i(scl_i), .sda_i(sda_i), .adr_sel(adr_sel),
  .sda_o(sda_o), .sda_oe(sda_oe), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .busy(busy));

/* File: verification/test_irs_target.sv */
/* Testbench for the I2C register access target with a register file model.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module test_irs_target;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic adr_sel = 1'b0;
  logic scl, sda_h, sda_o, sda_oe, busy;
  logic [7:0] reg_rdata = 8'h00;
  irs_pkg::irs_req_t reg_req;
  logic [7:0] mem [256];
  logic [8:0] rx;
  int num_errors = 0;
  int n_tests = 0;
  int n_wr = 0;
  wire sda = sda_h & ~sda_oe; // Open-drain wire with pull-up
  always #4 clk = ~clk;
  irs_target u_irs_target (.clk(clk), .srst(srst), .scl_i(scl),
    .sda_i(sda), .adr_sel(adr_sel), .sda_o(sda_o), .sda_oe(sda_oe),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .busy(busy));
  irs_host u_irs_host (.clk(clk), .scl(scl), .sda_h(sda_h), .sda(sda));
  // Register file: stores writes, answers a read in the next cycle
  always @(posedge clk) begin
    if (reg_req.wr) begin
      mem[reg_req.addr] <= reg_req.wdata;
      n_wr <= n_wr + 1;
    end
    reg_rdata <= reg_req.rd ? mem[reg_req.addr] : ~reg_rdata;
  end
  function automatic logic [7:0] ab(input logic s, input logic rw);
    return {1'b0, s, 5'h1d, rw};
  endfunction : ab
  task automatic send(input logic [7:0] b, input logic ack);
    u_irs_host.xb({b, 1'b1}, rx);
    `CHK(rx[0], ~ack)
  endtask : send
  task automatic recv(input logic host_ack, input logic [7:0] e);
    u_irs_host.xb({8'hff, ~host_ack}, rx);
    `CHK(rx[8:1], e)
  endtask : recv
  // Write one register, then an extra byte that must be refused
  task automatic t_write();
    int n0;
    n0 = n_wr;
    u_irs_host.start();
    send(ab(1'b0, 1'b0), 1'b1);
    send(8'h3c, 1'b1);
    send(8'ha5, 1'b1);
    send(8'h66, 1'b0);
    u_irs_host.stop();
    `CHK(mem[8'h3c], 8'ha5)
    `CHK(mem[8'h3d], 8'h67)
    `CHK(n_wr, n0 + 1)
    $display("t_write done");
  endtask : t_write
  // Command phases then reads, with repeat, repeated start and reuse
  task automatic t_read();
    u_irs_host.start();
    send(ab(1'b0, 1'b0), 1'b1);
    send(8'h21, 1'b1);
    u_irs_host.stop();
    u_irs_host.start();
    send(ab(1'b0, 1'b1), 1'b1);
    recv(1'b1, 8'h7b);
    recv(1'b0, 8'h7b);
    u_irs_host.stop();
    u_irs_host.start();
    send(ab(1'b0, 1'b0), 1'b1);
    send(8'h3c, 1'b1);
    u_irs_host.start();
    send(ab(1'b0, 1'b1), 1'b1);
    recv(1'b0, 8'ha5);
    u_irs_host.stop();
    u_irs_host.start();
    send(ab(1'b0, 1'b1), 1'b1);
    recv(1'b0, 8'ha5);
    u_irs_host.stop();
    `CHK(busy, 1'b0)
    $display("t_read done");
  endtask : t_read
  // Select pin moves the address; wrong addresses are not answered
  task automatic t_sel();
    adr_sel = 1'b1;
    u_irs_host.start();
    send(ab(1'b0, 1'b0), 1'b0);
    u_irs_host.stop();
    u_irs_host.start();
    send(8'h78, 1'b0);
    u_irs_host.stop();
    u_irs_host.start();
    send(ab(1'b1, 1'b0), 1'b1);
    send(8'h10, 1'b1);
    send(8'h77, 1'b1);
    u_irs_host.stop();
    `CHK(mem[8'h10], 8'h77)
    $display("t_sel done");
  endtask : t_sel
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    `CHK(sda_oe, 1'b0)
    `CHK(sda_o, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(reg_req, 18'h00000)
    t_write();
    t_read();
    t_sel();
    wrap_up();
  end
  // Watchdog
  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
endmodule : test_irs_target
